// ### logic/rsc_pkg.sv
// Constants and types shared by the reset source controller
package rsc_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_RESET_SOURCE   = 8'hEF;
   localparam logic [7:0] ADDR_SUPPLY_CTRL    = 8'hFF;
   localparam logic [7:0] ADDR_WDOG_CTRL      = 8'hD9;
   localparam logic [7:0] ADDR_WDOG_LIMIT     = 8'hDA;
   localparam logic [7:0] ADDR_WDOG_KICK      = 8'hDB;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int BIT_PIN_FLAG     = 0;
   localparam int BIT_POR_FLAG     = 1;
   localparam int BIT_CLK_LOSS     = 2;
   localparam int BIT_WDOG_FLAG    = 3;
   localparam int BIT_COMP_SELECT  = 5;
   localparam int BIT_SUPPLY_EN    = 7;
   localparam int BIT_SUPPLY_LEVEL = 6;
   localparam int BIT_WDOG_EN      = 0;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_WDOG_LIMIT = 8'hFF;
   localparam logic [7:0] RST_RDATA      = 8'h00;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 8;
   localparam int MCD_TIMEOUT_NS  = 100000;
   localparam int MCD_CYCLES      =
      (MCD_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WDOG_DIVIDE     = 12;
   localparam int POR_HOLD_CYCLES = 16;
   localparam int MIN_HOLD_CYCLES = 4;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_POR   = 2'b00,
      ST_RUN   = 2'b01,
      ST_RESET = 2'b11
   } rsc_state_e;

   typedef struct packed {
      logic pin;
      logic supply;
      logic clkLoss;
      logic comp;
      logic wdog;
   } rsc_cause_s;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } rsc_bus_req_s;

   typedef struct packed {
      rsc_state_e  state;
      logic [15:0] holdCnt;
      logic [15:0] mcdCnt;
      logic        clkPrev;
      rsc_cause_s  seen;
      logic        pinFlag;
      logic        porFlag;
      logic        clkLossFlag;
      logic        wdogFlag;
      logic        compSelect;
      logic        supplySelect;
      logic        supplyEnable;
      logic        mcdEnable;
      logic        pinDrive;
      logic        pinDrivePrev;
      logic        coreRst;
      logic [7:0]  wdogLimit;
      logic [7:0]  rdata;
   } rsc_ctl_s;

   typedef struct packed {
      logic [3:0]  div;
      logic [15:0] cnt;
      logic        enable;
      logic        expire;
   } rsc_wd_s;

endpackage

// ### logic/rsc_wdog.sv
// Single 16-bit counter watchdog clocked by a divided-by-twelve enable
`timescale 1ns/1ps
`default_nettype none
module rsc_wdog #(
   parameter int CNT_W = 16
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // Control
   input  wire logic              coreRst,
   input  wire logic              enableWr,
   input  wire logic              enableVal,
   input  wire logic              kick,
   input  wire logic [7:0]        limit,
   // Status
   output logic                   enabled,
   output logic [7:0]             countHigh,
   output logic                   expire
);

   rsc_pkg::rsc_wd_s st_reg;
   rsc_pkg::rsc_wd_s st_next;
   logic             tick;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.expire = 1'b0;
      tick = (st_reg.div == 4'(rsc_pkg::WDOG_DIVIDE - 1));
      if (tick) begin
         st_next.div = 4'h0;
      end else begin
         st_next.div = st_reg.div + 4'h1;
      end
      if (coreRst) begin
         st_next.enable = 1'b1;
         st_next.cnt    = 16'h0000;
         st_next.div    = 4'h0;
      end else begin
         if (enableWr) begin
            st_next.enable = enableVal;
         end
         if (kick || !st_reg.enable) begin
            st_next.cnt = 16'h0000;
         end else if (tick) begin
            if (st_reg.cnt == {limit, 8'hFF}) begin
               st_next.expire = 1'b1;
               st_next.cnt    = 16'h0000;
            end else begin
               st_next.cnt = st_reg.cnt + 16'h0001;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '{div: 4'h0, cnt: 16'h0000, enable: 1'b1,
                     expire: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign enabled   = st_reg.enable;
   assign countHigh = st_reg.cnt[15:8];
   assign expire    = st_reg.expire;

endmodule
`default_nettype wire

// ### logic/rsc_reset_source_controller.sv
// Reset source controller: merges reset causes and records them
//
// Overview of operation
// - External pin held low puts the device into system reset.
// - Leaving a pin reset sets the pin flag, bit 0.
// - Enabled clock-loss detector resets when the clock stalls over 100 us.
// - Clock-loss flag bit 2 reads one only after a clock-loss reset.
// - Writing bit 2 enables or disables the clock-loss detector.
// - Clock-loss, comparator and watchdog resets never drive the pin.
// - Writing one to bit 5 selects the comparator as reset source.
// - Selected comparator holds reset while its output is low.
// - Bit 5 reads back the comparator select; a comparator reset sets it, other resets clear it.
// - After any reset the watchdog is enabled, clocked at clock/12.
// - Unserviced watchdog expiry resets and sets the watchdog flag.
// - Power-on flag set by power-on and supply-monitor resets, cleared by other resets.
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_source_controller #(
   parameter int MCD_LIMIT = rsc_pkg::MCD_CYCLES,
   parameter int POR_HOLD  = rsc_pkg::POR_HOLD_CYCLES,
   parameter int MIN_HOLD  = rsc_pkg::MIN_HOLD_CYCLES
) (
   // Clock and power-on reset
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // Register port
   input  wire rsc_pkg::rsc_bus_req_s busReq,
   output logic [7:0]                rdata,
   // External reset pin, open drain
   input  wire logic                 rstPinIn_n,
   output logic                      rstPinOut,
   output logic                      rstPinOe,
   // Analog sources
   input  wire logic                 monitoredClk,
   input  wire logic                 compOut,
   input  wire logic                 supplyAbove,
   // Core reset
   output logic                      coreRst
);

   rsc_pkg::rsc_ctl_s   st_reg;
   rsc_pkg::rsc_ctl_s   st_next;
   rsc_pkg::rsc_cause_s cause;
   logic                anyCause;
   logic                mcdTimeout;
   logic                wdEnabled;
   logic [7:0]          wdCountHigh;
   logic                wdExpire;
   logic                wrOk;
   logic                rdOk;
   logic                wdEnableWr;
   logic                wdKick;

   // ----------------------------------------------------------------
   // Register read and write decode
   // ----------------------------------------------------------------
   assign wrOk = busReq.wr && (st_reg.state == rsc_pkg::ST_RUN);
   assign rdOk = busReq.rd && (st_reg.state == rsc_pkg::ST_RUN);
   assign wdEnableWr = wrOk && (busReq.addr == rsc_pkg::ADDR_WDOG_CTRL);
   assign wdKick     = wrOk && (busReq.addr == rsc_pkg::ADDR_WDOG_KICK);

   // ----------------------------------------------------------------
   // Watchdog
   // ----------------------------------------------------------------
   rsc_wdog #(
      .CNT_W     (16)
   ) u_wdog (
      .clk       (clk),
      .rst_n     (rst_n),
      .coreRst   (st_reg.coreRst),
      .enableWr  (wdEnableWr),
      .enableVal (busReq.wdata[rsc_pkg::BIT_WDOG_EN]),
      .kick      (wdKick),
      .limit     (st_reg.wdogLimit),
      .enabled   (wdEnabled),
      .countHigh (wdCountHigh),
      .expire    (wdExpire)
   );

   // ----------------------------------------------------------------
   // Cause detection
   // ----------------------------------------------------------------
   assign mcdTimeout = (st_reg.mcdCnt == 16'(MCD_LIMIT));

   always_comb begin
      cause.pin     = !rstPinIn_n && !st_reg.pinDrive
                      && !st_reg.pinDrivePrev;
      cause.supply  = st_reg.supplySelect && st_reg.supplyEnable
                      && !supplyAbove;
      cause.clkLoss = st_reg.mcdEnable && mcdTimeout;
      cause.comp    = st_reg.compSelect && !compOut;
      cause.wdog    = wdExpire;
      anyCause      = |cause;
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.clkPrev      = monitoredClk;
      st_next.pinDrivePrev = st_reg.pinDrive;
      st_next.rdata        = rsc_pkg::RST_RDATA;

      // One-shot restarted by every clock level change
      if (monitoredClk != st_reg.clkPrev) begin
         st_next.mcdCnt = 16'h0000;
      end else if (!mcdTimeout) begin
         st_next.mcdCnt = st_reg.mcdCnt + 16'h0001;
      end

      unique case (st_reg.state)
         rsc_pkg::ST_POR: begin
            st_next.pinDrive = 1'b1;
            if (st_reg.holdCnt >= 16'(POR_HOLD - 1)) begin
               st_next.state       = rsc_pkg::ST_RUN;
               st_next.pinDrive    = 1'b0;
               st_next.porFlag     = 1'b1;
               st_next.pinFlag     = 1'b0;
               st_next.clkLossFlag = 1'b0;
               st_next.wdogFlag    = 1'b0;
               st_next.compSelect  = 1'b0;
            end else begin
               st_next.holdCnt = st_reg.holdCnt + 16'h0001;
            end
         end
         rsc_pkg::ST_RUN: begin
            if (anyCause) begin
               st_next.state   = rsc_pkg::ST_RESET;
               st_next.seen    = cause;
               st_next.holdCnt = 16'h0000;
               st_next.pinDrive = cause.supply;
            end
         end
         rsc_pkg::ST_RESET: begin
            st_next.seen     = st_reg.seen | cause;
            st_next.pinDrive = cause.supply;
            if (st_reg.holdCnt != 16'(MIN_HOLD)) begin
               st_next.holdCnt = st_reg.holdCnt + 16'h0001;
            end
            if (!anyCause && (st_reg.holdCnt == 16'(MIN_HOLD))) begin
               st_next.state       = rsc_pkg::ST_RUN;
               st_next.pinDrive    = 1'b0;
               st_next.pinFlag     = st_reg.seen.pin;
               st_next.porFlag     = st_reg.seen.supply;
               st_next.clkLossFlag = st_reg.seen.clkLoss;
               st_next.wdogFlag    = st_reg.seen.wdog;
               st_next.compSelect  = st_reg.seen.comp;
            end
         end
      endcase

      // Register writes
      if (wrOk) begin
         unique case (busReq.addr)
            rsc_pkg::ADDR_RESET_SOURCE: begin
               st_next.supplySelect =
                  busReq.wdata[rsc_pkg::BIT_POR_FLAG];
               st_next.mcdEnable =
                  busReq.wdata[rsc_pkg::BIT_CLK_LOSS];
               st_next.compSelect =
                  busReq.wdata[rsc_pkg::BIT_COMP_SELECT];
            end
            rsc_pkg::ADDR_SUPPLY_CTRL: begin
               st_next.supplyEnable =
                  busReq.wdata[rsc_pkg::BIT_SUPPLY_EN];
            end
            rsc_pkg::ADDR_WDOG_LIMIT: begin
               st_next.wdogLimit = busReq.wdata;
            end
            default: begin
            end
         endcase
      end

      // Register reads
      if (rdOk) begin
         unique case (busReq.addr)
            rsc_pkg::ADDR_RESET_SOURCE: begin
               st_next.rdata[rsc_pkg::BIT_PIN_FLAG]    = st_reg.pinFlag;
               st_next.rdata[rsc_pkg::BIT_POR_FLAG]    = st_reg.porFlag;
               st_next.rdata[rsc_pkg::BIT_CLK_LOSS]    =
                  st_reg.clkLossFlag;
               st_next.rdata[rsc_pkg::BIT_WDOG_FLAG]   = st_reg.wdogFlag;
               st_next.rdata[rsc_pkg::BIT_COMP_SELECT] =
                  st_reg.compSelect;
            end
            rsc_pkg::ADDR_SUPPLY_CTRL: begin
               st_next.rdata[rsc_pkg::BIT_SUPPLY_EN]    =
                  st_reg.supplyEnable;
               st_next.rdata[rsc_pkg::BIT_SUPPLY_LEVEL] = supplyAbove;
            end
            rsc_pkg::ADDR_WDOG_CTRL: begin
               st_next.rdata[rsc_pkg::BIT_WDOG_EN] = wdEnabled;
            end
            rsc_pkg::ADDR_WDOG_LIMIT: begin
               st_next.rdata = st_reg.wdogLimit;
            end
            rsc_pkg::ADDR_WDOG_KICK: begin
               st_next.rdata = wdCountHigh;
            end
            default: begin
            end
         endcase
      end

      st_next.coreRst = (st_next.state != rsc_pkg::ST_RUN);
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg.state        <= rsc_pkg::ST_POR;
         st_reg.holdCnt      <= 16'h0000;
         st_reg.mcdCnt       <= 16'h0000;
         st_reg.clkPrev      <= 1'b0;
         st_reg.seen         <= '0;
         st_reg.pinFlag      <= 1'b0;
         st_reg.porFlag      <= 1'b0;
         st_reg.clkLossFlag  <= 1'b0;
         st_reg.wdogFlag     <= 1'b0;
         st_reg.compSelect   <= 1'b0;
         st_reg.supplySelect <= 1'b0;
         st_reg.supplyEnable <= 1'b0;
         st_reg.mcdEnable    <= 1'b0;
         st_reg.pinDrive     <= 1'b1;
         st_reg.pinDrivePrev <= 1'b1;
         st_reg.coreRst      <= 1'b1;
         st_reg.wdogLimit    <= rsc_pkg::RST_WDOG_LIMIT;
         st_reg.rdata        <= rsc_pkg::RST_RDATA;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign rdata     = st_reg.rdata;
   assign rstPinOut = 1'b0;
   assign rstPinOe  = st_reg.pinDrive;
   assign coreRst   = st_reg.coreRst;

endmodule
`default_nettype wire

// ### tb/rsc_pin_model.sv
// External reset circuitry on the open-drain reset pin
`timescale 1ns/1ps
`default_nettype none
module rsc_pin_model (
   // Clock
   input  wire logic       clk,
   // Pulse request
   input  wire logic       start,
   input  wire logic [7:0] len,
   // Pin
   input  wire logic       oe,
   output logic            pinLvl_n
);
   logic [7:0] left = 8'h00;

   // Pull-up unless either side sinks the pin
   assign pinLvl_n = !(oe || left != 8'h00);

   always @(posedge clk) begin
      if (start)
         left <= len;
      else if (left != 8'h00)
         left <= left - 8'h01;
   end
endmodule
`default_nettype wire

// ### tb/rsc_reset_source_controller_chk.sv
// Port assertions for the reset source controller
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_source_controller_chk #(
   parameter int MCD_LIMIT = 20
) (
   // Clock and reset
   input wire logic                  clk,
   input wire logic                  rst_n,
   // Register port
   input wire rsc_pkg::rsc_bus_req_s busReq,
   input wire logic [7:0]            rdata,
   // Pin, sources, core reset
   input wire logic                  rstPinIn_n,
   input wire logic                  rstPinOut,
   input wire logic                  rstPinOe,
   input wire logic                  monitoredClk,
   input wire logic                  compOut,
   input wire logic                  supplyAbove,
   input wire logic                  coreRst
);
   logic        mcdOn;
   logic        clkPrev;
   logic [15:0] stall;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Detector enable mirror and stall length
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mcdOn   <= 1'b0;
         clkPrev <= 1'b0;
         stall   <= 16'h0000;
      end else begin
         clkPrev <= monitoredClk;
         if (busReq.wr && !coreRst &&
             busReq.addr == rsc_pkg::ADDR_RESET_SOURCE)
            mcdOn <= busReq.wdata[rsc_pkg::BIT_CLK_LOSS];
         if (monitoredClk != clkPrev)
            stall <= 16'h0000;
         else if (stall != 16'hFFFF)
            stall <= stall + 16'h0001;
      end
   end

   property p_pin_quiet;
      rstPinOut == 1'b0;
   endproperty
   a_pin_quiet: assert property (p_pin_quiet)
      else $error("reset pin output not low");

   property p_pin_rst;
      !rstPinIn_n && !rstPinOe && !$past(rstPinOe) &&
      !$past(rstPinOe, 2) |=> coreRst;
   endproperty
   a_pin_rst: assert property (p_pin_rst)
      else $error("low pin did not reset core");

   property p_hold;
      $rose(coreRst) |-> coreRst[*5];
   endproperty
   a_hold: assert property (p_hold)
      else $error("core reset too short");

   property p_no_drive;
      $rose(coreRst) && supplyAbove && $past(supplyAbove) |-> !rstPinOe;
   endproperty
   a_no_drive: assert property (p_no_drive)
      else $error("internal reset drove the pin");

   property p_oe_in_rst;
      rstPinOe |-> coreRst;
   endproperty
   a_oe_in_rst: assert property (p_oe_in_rst)
      else $error("pin driven outside reset");

   property p_mcd;
      mcdOn && !coreRst && stall == 16'(MCD_LIMIT) |-> ##[0:3] coreRst;
   endproperty
   a_mcd: assert property (p_mcd)
      else $error("stalled clock not detected");

   property p_rd_idle;
      !$past(busReq.rd) |-> rdata == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data outside read slot");

   property p_supply_rd;
      $past(busReq.rd) && !$past(coreRst) &&
      $past(busReq.addr) == rsc_pkg::ADDR_SUPPLY_CTRL
      |-> rdata[rsc_pkg::BIT_SUPPLY_LEVEL] == $past(supplyAbove);
   endproperty
   a_supply_rd: assert property (p_supply_rd)
      else $error("supply level bit wrong");

   c_pin: cover property ($rose(coreRst) && !rstPinIn_n);
   c_mcd: cover property (mcdOn && stall == 16'(MCD_LIMIT));
   c_cmp: cover property ($rose(coreRst) && !compOut);
   c_sup: cover property ($rose(coreRst) && rstPinOe && !supplyAbove);
endmodule

bind rsc_reset_source_controller rsc_reset_source_controller_chk #(
   .MCD_LIMIT(MCD_LIMIT)) chk (.clk(clk), .rst_n(rst_n),
   .busReq(busReq), .rdata(rdata), .rstPinIn_n(rstPinIn_n),
   .rstPinOut(rstPinOut), .rstPinOe(rstPinOe),
   .monitoredClk(monitoredClk), .compOut(compOut),
   .supplyAbove(supplyAbove), .coreRst(coreRst));
`default_nettype wire

// ### tb/reset_source_controller_test.sv
// Self-checking bench for the reset source controller
`timescale 1ns/1ps
`default_nettype none
module reset_source_controller_test;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic [7:0] exp;
   } rsc_row_s;

   logic                  clk          = 1'b0;
   logic                  rst_n        = 1'b0;
   rsc_pkg::rsc_bus_req_s busReq       = '0;
   logic [7:0]            rdata;
   logic                  rstPinIn_n;
   logic                  rstPinOut;
   logic                  rstPinOe;
   logic                  coreRst;
   logic                  monitoredClk = 1'b0;
   logic                  clkRun       = 1'b1;
   logic                  compOut      = 1'b1;
   logic                  supplyAbove  = 1'b1;
   logic                  pulseGo      = 1'b0;
   logic [7:0]            pulseLen     = 8'h00;
   int                    mismatches   = 0;
   int                    checks       = 0;
   rsc_row_s              rows [10]    = '{
      '{8'hEF, 8'h00, 1'b0, 8'h02}, '{8'hD9, 8'h00, 1'b0, 8'h01},
      '{8'hDA, 8'h00, 1'b0, 8'hFF}, '{8'hFF, 8'h00, 1'b0, 8'h40},
      '{8'hFF, 8'h80, 1'b1, 8'h00}, '{8'hFF, 8'h00, 1'b0, 8'hC0},
      '{8'h10, 8'hAA, 1'b1, 8'h00}, '{8'h10, 8'h00, 1'b0, 8'h00},
      '{8'hEF, 8'h04, 1'b1, 8'h00}, '{8'hEF, 8'h00, 1'b0, 8'h02}};
   logic [7:0]            lens [2]     = '{8'h01, 8'h28};

   always #4 clk = ~clk;
   always @(posedge clk) if (clkRun) monitoredClk <= ~monitoredClk;

   rsc_reset_source_controller #(.MCD_LIMIT(20)) uut (
      .clk(clk), .rst_n(rst_n), .busReq(busReq), .rdata(rdata),
      .rstPinIn_n(rstPinIn_n), .rstPinOut(rstPinOut),
      .rstPinOe(rstPinOe), .monitoredClk(monitoredClk),
      .compOut(compOut), .supplyAbove(supplyAbove), .coreRst(coreRst));
   rsc_pin_model ext (.clk(clk), .start(pulseGo), .len(pulseLen),
      .oe(rstPinOe), .pinLvl_n(rstPinIn_n));

   // ------------------------------
   // Tasks
   // ------------------------------
   task automatic results();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic regWr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      busReq <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      busReq.wr <= 1'b0;
   endtask

   task automatic regRd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      busReq <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      busReq.rd <= 1'b0;
      #1 d = rdata;
   endtask

   // Core reset must rise, then fall, within lim cycles
   task automatic waitRst(input int lim, output int n);
      n = 0;
      while (coreRst !== 1'b1 && n < lim) begin
         @(negedge clk);
         n++;
      end
      while (coreRst !== 1'b0 && n < lim) begin
         @(negedge clk);
         n++;
      end
      if (n >= lim) begin
         mismatches++;
         $display("FAIL %0t reset wait ran out", $time);
         results();
      end
   endtask

   task automatic pinPulse(input logic [7:0] len);
      @(posedge clk);
      pulseLen <= len;
      pulseGo  <= 1'b1;
      @(posedge clk);
      pulseGo  <= 1'b0;
   endtask

   // ------------------------------
   // Sequence
   // ------------------------------
   initial begin
      logic [7:0] d;
      int         n;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (12) @(negedge clk);
      chk({6'h00, coreRst, rstPinOe}, 8'h03);
      waitRst(20, n);
      $display("power-on reset done");
      foreach (rows[i]) begin
         if (rows[i].wr)
            regWr(rows[i].addr, rows[i].wdata);
         else begin
            regRd(rows[i].addr, d);
            chk(d, rows[i].exp);
         end
      end
      $display("register table done");
      foreach (lens[i]) begin
         pinPulse(lens[i]);
         waitRst(200, n);
         chk({7'h00, n + 3 >= int'(lens[i])}, 8'h01);
         regRd(8'hEF, d);
         chk(d, 8'h01);
      end
      $display("pin reset done");
      // monitor enabled by the table, settled, then selected
      regWr(8'hEF, 8'h02);
      @(posedge clk) supplyAbove <= 1'b0;
      repeat (3) @(negedge clk);
      chk({6'h00, coreRst, rstPinOe}, 8'h03);
      @(posedge clk) supplyAbove <= 1'b1;
      waitRst(100, n);
      regRd(8'hEF, d);
      chk(d, 8'h02);
      $display("supply reset done");
      @(posedge clk) compOut <= 1'b0;
      repeat (10) @(negedge clk);
      chk({7'h00, coreRst}, 8'h00);
      @(posedge clk) compOut <= 1'b1;
      regWr(8'hEF, 8'h24);
      @(posedge clk) compOut <= 1'b0;
      repeat (20) @(posedge clk);
      compOut <= 1'b1;
      waitRst(100, n);
      regRd(8'hEF, d);
      chk(d, 8'h20);
      $display("comparator reset done");
      for (int e = 1; e >= 0; e--) begin
         regWr(8'hEF, {5'h00, e[0], 2'h0});
         clkRun <= 1'b0;
         repeat (24) @(negedge clk);
         chk({7'h00, coreRst}, {7'h00, e[0]});
         @(posedge clk) clkRun <= 1'b1;
         if (e == 1) begin
            waitRst(100, n);
            regRd(8'hEF, d);
            chk(d, 8'h04);
         end
      end
      $display("clock loss reset done");
      regWr(8'hDA, 8'h00);
      repeat (1500) @(posedge clk);
      regWr(8'hDB, 8'h00);
      repeat (3030) @(negedge clk);
      chk({7'h00, coreRst}, 8'h00);
      waitRst(80, n);
      regRd(8'hEF, d);
      chk(d, 8'h08);
      regRd(8'hD9, d);
      chk(d, 8'h01);
      regWr(8'hD9, 8'h00);
      regRd(8'hD9, d);
      chk(d, 8'h00);
      $display("watchdog reset done");
      results();
   end
endmodule
`default_nettype wire
